/* src/eipc_defs.vh */
/*
 constants for the external request and priority-b controller.
 assumes inclusion by src/eipc_ctrl.v only.
*/
`ifndef EIPC_DEFS_VH
`define EIPC_DEFS_VH

// ----------------------------------------
// register offsets (own choice)
// ----------------------------------------
`define EIPC_OFS_SENSE 4'h0
`define EIPC_OFS_ENABLE 4'h1
`define EIPC_OFS_STATUS 4'h2
`define EIPC_OFS_PRIO_B 4'h3
`define EIPC_OFS_CTRL 4'h4

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define EIPC_RST_BYTE 8'h00
`define EIPC_STATUS_MASK 8'h3F
`define EIPC_CTRL_MASK 8'h01
`define EIPC_BIT_TMR3 7
`define EIPC_BIT_TMR4 6
`define EIPC_BIT_DMA 5
`define EIPC_BIT_SER0 3
`define EIPC_BIT_SER1 2
`define EIPC_BIT_ADC 1
`define EIPC_BIT_NMI_EDGE 0

// ----------------------------------------
// exception vector numbers
// ----------------------------------------
`define EIPC_VEC_NMI 8'h07
`define EIPC_VEC_LINE0 8'h0C
`define EIPC_VEC_NONE 8'h00

`endif

/* src/eipc_ctrl.v */
/*
 external request lines, nmi detection and second priority register.
 assumes a single-cycle register port, pins asynchronous to core_clk_i,
 and a cpu that pulses ack_i with the taken vector number.
*/
// Chosen here: the strobed register port and the placing of the registers.
// Function
// - reset and hardware standby clear priority, status, enable, sense registers.
// - priority bit 7 sets timer channel 3, bit 6 channel 4 level.
// - priority bit 5 sets level of both dma channel requests.
// - priority bit 3 sets serial channel 0, bit 2 channel 1 level.
// - priority bit 1 sets converter request level.
// - priority bits 4 and 0 are plain storage.
// - status bits 7 and 6 read zero.
// - software writes can only clear status flags.
// - flag sets on low level (sense 0) or falling edge (sense 1).
// - flag clears on zero write after it was read as one.
// - level mode flag clears when pin high and handling done.
// - edge mode flag clears when handling done.
// - enable bits 5..0 gate lines 5..0.
// - enable bits 7 and 6 are plain storage.
// - sense bits 5..0 pick low level or falling edge.
// - sense bits 7 and 6 are plain storage.
// - nmi outranks all and ignores cpu masks.
// - nmi taken on selected edge, vector 7.
// - lines 0..5 use vectors 12..17.
// - detection uses pin level whatever the port direction.
// - nmi and lines 0..2 wake from software standby, not 3..5.
// - nmi edge choice 0 falling, 1 rising.
`timescale 1ns/1ps
`include "eipc_defs.vh"

module eipc_ctrl #(
	parameter LINES = 6
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire hw_standby_i,
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire [LINES-1:0] line_pin_b_i,
	input wire nmi_pin_i,
	input wire ack_i,
	input wire [7:0] ack_vec_i,
	output reg nmi_req_o,
	output reg [LINES-1:0] line_req_o,
	output reg [LINES-1:0] line_level_o,
	output reg tmr3_level_o,
	output reg tmr4_level_o,
	output reg dma_level_o,
	output reg ser0_level_o,
	output reg ser1_level_o,
	output reg adc_level_o,
	output reg wake_o
);

// ----------------------------------------
// reset and pin synchronisers
// ----------------------------------------
reg [1:0] rst_sync_r;
wire rst_b;
reg [LINES-1:0] pin_s1_r;
reg [LINES-1:0] pin_s2_r;
reg [LINES-1:0] pin_prev_r;
reg nmi_s1_r;
reg nmi_s2_r;
reg nmi_prev_r;
reg stby_s1_r;
reg stby_s2_r;

always @(posedge core_clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
		rst_sync_r <= 2'h0;
	else
		rst_sync_r <= {rst_sync_r[0], 1'b1};
end
assign rst_b = rst_sync_r[1];

// pins sampled directly, so output-configured pins still detect
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		pin_s1_r <= {LINES{1'b1}};
		pin_s2_r <= {LINES{1'b1}};
		pin_prev_r <= {LINES{1'b1}};
	end
	else
	begin
		pin_s1_r <= line_pin_b_i;
		pin_s2_r <= pin_s1_r;
		pin_prev_r <= pin_s2_r;
	end
end

// idle-high reset values keep a false nmi edge away after reset
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		nmi_s1_r <= 1'b1;
		nmi_s2_r <= 1'b1;
		nmi_prev_r <= 1'b1;
	end
	else
	begin
		nmi_s1_r <= nmi_pin_i;
		nmi_s2_r <= nmi_s1_r;
		nmi_prev_r <= nmi_s2_r;
	end
end

// standby is a level, so no edge history is kept
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		stby_s1_r <= 1'b0;
		stby_s2_r <= 1'b0;
	end
	else
	begin
		stby_s1_r <= hw_standby_i;
		stby_s2_r <= stby_s1_r;
	end
end

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] prio_b_r;
reg [7:0] sense_r;
reg [7:0] enable_r;
reg [LINES-1:0] status_r;
reg [LINES-1:0] status_nxt;
reg [LINES-1:0] seen_one_r;
reg nmi_edge_r;
reg nmi_pend_r;
wire stby;
wire wr_status;
wire rd_status;
wire [LINES-1:0] set_ev;
wire [LINES-1:0] ack_hit;
wire nmi_ev;
wire nmi_ack;
integer i;

assign stby = stby_s2_r;
assign wr_status = reg_wr_i && (reg_addr_i == `EIPC_OFS_STATUS);
assign rd_status = reg_rd_i && (reg_addr_i == `EIPC_OFS_STATUS);

genvar g;
generate
	for (g = 0; g < LINES; g = g + 1)
	begin : g_line
		// low level or falling edge per sense bit
		assign set_ev[g] = sense_r[g] ? (pin_prev_r[g] & ~pin_s2_r[g]) : ~pin_s2_r[g];
		// vector 12 + n marks handling of line n
		assign ack_hit[g] = ack_i && (ack_vec_i == (`EIPC_VEC_LINE0 + g));
	end
endgenerate

// rising or falling nmi edge per choice bit
assign nmi_ev = nmi_edge_r ? (~nmi_prev_r & nmi_s2_r) : (nmi_prev_r & ~nmi_s2_r);
// cpu took the nmi vector
assign nmi_ack = ack_i && (ack_vec_i == `EIPC_VEC_NMI);

always @*
begin
	status_nxt = status_r;
	for (i = 0; i < LINES; i = i + 1)
	begin
		// zero write only clears after a read of one
		if (wr_status && !reg_wdata_i[i] && seen_one_r[i])
			status_nxt[i] = 1'b0;
		// auto clear on handling; level mode needs pin high
		if (ack_hit[i] && (sense_r[i] || pin_s2_r[i]))
			status_nxt[i] = 1'b0;
		// set wins over any clear in the same cycle
		if (set_ev[i])
			status_nxt[i] = 1'b1;
	end
end

// ----------------------------------------
// storage; standby clears like reset
// ----------------------------------------
// all bits stored, unused ones have no effect
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		prio_b_r <= `EIPC_RST_BYTE;
	else if (stby)
		prio_b_r <= `EIPC_RST_BYTE;
	else if (reg_wr_i && (reg_addr_i == `EIPC_OFS_PRIO_B))
		prio_b_r <= reg_wdata_i;
end

// top two sense bits kept but never decoded
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		sense_r <= `EIPC_RST_BYTE;
	else if (stby)
		sense_r <= `EIPC_RST_BYTE;
	else if (reg_wr_i && (reg_addr_i == `EIPC_OFS_SENSE))
		sense_r <= reg_wdata_i;
end

// top two enable bits kept but never decoded
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		enable_r <= `EIPC_RST_BYTE;
	else if (stby)
		enable_r <= `EIPC_RST_BYTE;
	else if (reg_wr_i && (reg_addr_i == `EIPC_OFS_ENABLE))
		enable_r <= reg_wdata_i;
end

// set wins over a clear in the same cycle, see status_nxt
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		status_r <= {LINES{1'b0}};
	else if (stby)
		status_r <= {LINES{1'b0}};
	else
		status_r <= status_nxt;
end

// a read arms the clear; a status write disarms it unless a status read comes in the same cycle
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		seen_one_r <= {LINES{1'b0}};
	else if (stby)
		seen_one_r <= {LINES{1'b0}};
	else if (rd_status)
		seen_one_r <= status_r;
	else if (wr_status)
		seen_one_r <= {LINES{1'b0}};
end

// edge choice in its own control byte, falling after reset
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		nmi_edge_r <= 1'b0;
	else if (stby)
		nmi_edge_r <= 1'b0;
	else if (reg_wr_i && (reg_addr_i == `EIPC_OFS_CTRL))
		nmi_edge_r <= reg_wdata_i[`EIPC_BIT_NMI_EDGE];
end

// nmi held until taken, no mask applies
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		nmi_pend_r <= 1'b0;
	else if (stby)
		nmi_pend_r <= 1'b0;
	else if (nmi_ev)
		nmi_pend_r <= 1'b1;
	else if (nmi_ack)
		nmi_pend_r <= 1'b0;
end

// ----------------------------------------
// outputs and read port
// ----------------------------------------
reg [7:0] rdata_nxt;

always @*
begin
	case (reg_addr_i)
		`EIPC_OFS_PRIO_B: rdata_nxt = prio_b_r;
		`EIPC_OFS_SENSE: rdata_nxt = sense_r;
		`EIPC_OFS_ENABLE: rdata_nxt = enable_r;
		// upper bits forced to zero
		`EIPC_OFS_STATUS: rdata_nxt = {2'h0, status_r} & `EIPC_STATUS_MASK;
		`EIPC_OFS_CTRL: rdata_nxt = {7'h00, nmi_edge_r} & `EIPC_CTRL_MASK;
		default: rdata_nxt = `EIPC_RST_BYTE;
	endcase
end

// outputs registered; one extra cycle of latency is the price
// read data stand one cycle after the strobe, zero otherwise
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		reg_rdata_o <= `EIPC_RST_BYTE;
	else
		reg_rdata_o <= reg_rd_i ? rdata_nxt : `EIPC_RST_BYTE;
end

// requests go out as levels; standby reaches them through the sources
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		nmi_req_o <= 1'b0;
		line_req_o <= {LINES{1'b0}};
		line_level_o <= {LINES{1'b0}};
	end
	else
	begin
		nmi_req_o <= nmi_pend_r;
		// flag and enable both needed
		line_req_o <= status_r & enable_r[LINES-1:0];
		line_level_o <= line_req_o;
	end
end

// timer channel levels
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		tmr3_level_o <= 1'b0;
		tmr4_level_o <= 1'b0;
	end
	else
	begin
		tmr3_level_o <= prio_b_r[`EIPC_BIT_TMR3];
		tmr4_level_o <= prio_b_r[`EIPC_BIT_TMR4];
	end
end

// one bit covers both dma channels
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		dma_level_o <= 1'b0;
	else
		dma_level_o <= prio_b_r[`EIPC_BIT_DMA];
end

// serial channel levels
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
	begin
		ser0_level_o <= 1'b0;
		ser1_level_o <= 1'b0;
	end
	else
	begin
		ser0_level_o <= prio_b_r[`EIPC_BIT_SER0];
		ser1_level_o <= prio_b_r[`EIPC_BIT_SER1];
	end
end

// converter level
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		adc_level_o <= 1'b0;
	else
		adc_level_o <= prio_b_r[`EIPC_BIT_ADC];
end

// only nmi and lines 0..2 may wake
always @(posedge core_clk_i or negedge rst_b)
begin
	if (!rst_b)
		wake_o <= 1'b0;
	else
		wake_o <= nmi_pend_r | (|(status_r[2:0] & enable_r[2:0]));
end

endmodule // eipc_ctrl

/* verification/eipc_ctrl_assertions.sv */
/* port checker for eipc_ctrl.
 assumes bind onto eipc_ctrl, one core clock. */
`timescale 1ns/1ps
module eipc_ctrl_chk #(
	parameter LINES = 6
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire hw_standby_i,
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire ack_i,
	input wire [7:0] ack_vec_i,
	input wire nmi_req_o,
	input wire [LINES-1:0] line_req_o,
	input wire tmr3_level_o,
	input wire tmr4_level_o,
	input wire dma_level_o,
	input wire ser0_level_o,
	input wire ser1_level_o,
	input wire adc_level_o,
	input wire wake_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!rst_b_i);
wire [5:0] lv = {tmr3_level_o, tmr4_level_o, dma_level_o, ser0_level_o, ser1_level_o, adc_level_o};
prio_map_a:
assert property (reg_wr_i && reg_addr_i == 4'h3 |-> ##2
	lv == {$past(reg_wdata_i[7:5], 2), $past(reg_wdata_i[3:1], 2)}) else $error("level map wrong");
prio_hold_a:
assert property ((!(reg_wr_i && reg_addr_i == 4'h3) && !hw_standby_i) [*3] |-> $stable(lv))
	else $error("level moved");
status_top_a:
assert property (reg_rd_i && reg_addr_i == 4'h2 |=> reg_rdata_o[7:6] == 2'h0)
	else $error("status top set");
nmi_clear_a:
assert property (ack_i && ack_vec_i == 8'h07 |-> ##2 !nmi_req_o) else $error("nmi kept");
nmi_stay_a:
assert property (nmi_req_o && !ack_i && !$past(ack_i) |=> nmi_req_o) else $error("nmi lost");
wake_nmi_a:
assert property (nmi_req_o |-> ##[0:1] wake_o) else $error("no wake");
wake_high_a:
assert property ((line_req_o[2:0] == 3'h0 && !nmi_req_o) [*2] |-> !wake_o)
	else $error("wrong wake");
standby_clr_a:
assert property (hw_standby_i [*4] |=> lv == 6'h00 && line_req_o == 6'h00 && !nmi_req_o)
	else $error("standby left state");
endmodule // eipc_ctrl_chk
bind eipc_ctrl eipc_ctrl_chk #(.LINES(LINES)) chk_u (.core_clk_i, .rst_b_i, .hw_standby_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ack_i, .ack_vec_i,
	.nmi_req_o, .line_req_o, .tmr3_level_o, .tmr4_level_o, .dma_level_o, .ser0_level_o,
	.ser1_level_o, .adc_level_o, .wake_o);

/* verification/eipc_cpu_model.sv */
/* cpu side: acks one pending request per take pulse.
 assumes take_i is a one-cycle pulse. */
`timescale 1ns/1ps
module eipc_cpu_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic take_i,
	input wire logic nmi_req_i,
	input wire logic [5:0] line_req_i,
	output logic ack_o,
	output logic [7:0] vec_o
);
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		ack_o <= 1'h0;
		vec_o <= 8'h00;
	end
	else
	begin
		ack_o <= take_i;
		// idle vector toggles, so a stale value comes back every second cycle
		vec_o <= ~vec_o;
		for (int i = 5; i >= 0; i--)
			if (take_i && line_req_i[i])
				vec_o <= 8'h0C + 8'(i);
		if (take_i && nmi_req_i)
			vec_o <= 8'h07;
	end
end
endmodule // eipc_cpu_model

/* verification/tb_ext_irq_and_priority_b_ctrl.sv */
/* self-checking bench for eipc_ctrl with a cpu model.
 assumes a 20 MHz clock and the checker bound in. */
`timescale 1ns/1ps
module tb_ext_irq_and_priority_b_ctrl;
logic core_clk_i = 0, rst_b_i = 0, hw_standby_i = 0, reg_wr_i = 0, reg_rd_i = 0;
logic nmi_pin_i = 1, take = 0;
logic [3:0] reg_addr_i = 0;
logic [7:0] reg_wdata_i = 0;
// pins serve only as request inputs, no other function
logic [5:0] line_pin_b_i = 6'h3F;
wire [7:0] reg_rdata_o, ack_vec_i;
wire [5:0] line_req_o, line_level_o;
wire ack_i, nmi_req_o, wake_o, tmr3_level_o, tmr4_level_o, dma_level_o;
wire ser0_level_o, ser1_level_o, adc_level_o;
wire [7:0] lv = {2'h0, tmr3_level_o, tmr4_level_o, dma_level_o, ser0_level_o, ser1_level_o,
	adc_level_o};
int mismatches = 0, n_compared = 0, cyc = 0;
eipc_ctrl dut_u (.core_clk_i, .rst_b_i, .hw_standby_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .line_pin_b_i, .nmi_pin_i, .ack_i, .ack_vec_i, .nmi_req_o,
	.line_req_o, .line_level_o, .tmr3_level_o, .tmr4_level_o, .dma_level_o, .ser0_level_o,
	.ser1_level_o, .adc_level_o, .wake_o);
eipc_cpu_model cpu_u (.clk_i(core_clk_i), .rst_b_i, .take_i(take), .nmi_req_i(nmi_req_o),
	.line_req_i(line_req_o), .ack_o(ack_i), .vec_o(ack_vec_i));
always #25 core_clk_i = ~core_clk_i;
// ----------------------------------------
// bus and check tasks
// ----------------------------------------
task w(input int n); repeat (n) @(posedge core_clk_i); endtask
task go; @(posedge core_clk_i) take <= 1; @(posedge core_clk_i) take <= 0; endtask
task chk(input string n, input logic [7:0] s, input logic [7:0] e);
	n_compared++;
	if (s !== e)
	begin
		mismatches++;
		$display("BAD %s exp %h seen %h", n, e, s);
	end
endtask
task wr(input logic [3:0] x, input logic [7:0] d);
	@(posedge core_clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {x, d, 1'h1};
	@(posedge core_clk_i) reg_wr_i <= 0;
endtask
task rc(input logic [3:0] x, input logic [7:0] e);
	@(posedge core_clk_i) {reg_addr_i, reg_rd_i} <= {x, 1'h1};
	@(posedge core_clk_i) reg_rd_i <= 0;
	@(negedge core_clk_i) chk("rdata", reg_rdata_o, e);
endtask
task end_of_test;
	$display("compared %0d mismatches %0d", n_compared, mismatches);
	if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_store;
	wr(4'h3, 8'hA4);
	w(2);
	chk("lvl", lv, 8'h2A);
	rc(4'h3, 8'hA4);
	wr(4'h3, 8'h5B);
	wr(4'h1, 8'hC0);
	wr(4'h0, 8'hC0);
	chk("lvl", lv, 8'h15);
	rc(4'h3, 8'h5B);
	rc(4'h1, 8'hC0);
	rc(4'h0, 8'hC0);
endtask
task t_lvl;
	wr(4'h1, 8'h3F);
	wr(4'h0, 8'h00);
	line_pin_b_i[0] <= 0;
	w(6);
	chk("req", line_req_o, 8'h01);
	chk("wake", wake_o, 8'h01);
	wr(4'h2, 8'h00);
	line_pin_b_i[0] <= 1;
	w(4);
	rc(4'h2, 8'h01);
	wr(4'h2, 8'h00);
	rc(4'h2, 8'h00);
	wr(4'h2, 8'hFF);
	rc(4'h2, 8'h00);
	line_pin_b_i[3] <= 0;
	w(6);
	chk("wake", wake_o, 8'h00);
	line_pin_b_i[3] <= 1;
	w(4);
	go;
	w(6);
	chk("req", line_req_o, 8'h00);
endtask
task t_edge;
	wr(4'h0, 8'h02);
	line_pin_b_i[1] <= 0;
	w(6);
	line_pin_b_i[1] <= 1;
	wr(4'h1, 8'h3D);
	w(4);
	chk("req", line_req_o, 8'h00);
	wr(4'h1, 8'h3F);
	w(3);
	chk("req", line_req_o, 8'h02);
	chk("lvl1", line_level_o, 8'h02);
	go;
	w(6);
	rc(4'h2, 8'h00);
endtask
task t_nmi;
	for (int e = 0; e < 2; e++)
	begin
		wr(4'h4, 8'(e));
		nmi_pin_i <= e[0];
		w(6);
		chk("nmi", nmi_req_o, 8'h01);
		go;
		w(6);
		chk("nmi", nmi_req_o, 8'h00);
	end
endtask
always @(posedge core_clk_i)
begin
	cyc++;
	if (cyc > 3000)
	begin
		mismatches++;
		end_of_test;
	end
end
initial
begin
	w(16);
	rst_b_i <= 1;
	w(4);
	for (int i = 0; i < 5; i++)
		rc(4'(i), 8'h00);
	rc(4'hF, 8'h00);
	t_store;
	t_lvl;
	t_edge;
	t_nmi;
	hw_standby_i <= 1;
	w(6);
	hw_standby_i <= 0;
	w(3);
	rc(4'h1, 8'h00);
	end_of_test;
end
endmodule // tb_ext_irq_and_priority_b_ctrl
